/* hw/lsrctl_pkg.sv */
// Constants shared by the laser enable and interlock control logic.
// Assumes a single 250 MHz clock; all times are turned into cycle counts here.
`default_nettype none
package lsrctl_pkg;
    // Clock rate in kHz, period 4 ns.
    localparam int unsigned CLK_KHZ = 250000;
    // Start-up delay after the reset/start request clears or the interlock returns.
    localparam int unsigned START_DELAY_S = 5;
    localparam longint unsigned START_DELAY_CYC = 64'(START_DELAY_S) * 64'(CLK_KHZ) * 64'd1000;
    // Debounce settle time for the isolated inputs, in microseconds.
    localparam int unsigned DEBOUNCE_US = 1000;
    localparam int unsigned DEBOUNCE_CYC = (DEBOUNCE_US * CLK_KHZ) / 1000;
    localparam int unsigned CNT_W = 32;
    localparam int unsigned DB_W = 20;
    // Power command resolution: duty measured over one period in clock cycles.
    localparam int unsigned PWR_W = 8;
    // Duty of 50 percent maps to full power code, 25 percent to about half.
    localparam int unsigned DUTY_FULL_PCT10 = 500;
    localparam logic [PWR_W-1:0] PWR_FULL = 8'hFF;
    localparam logic [PWR_W-1:0] PWR_RESET = 8'h00;
    // Enable state machine.
    typedef enum logic [1:0] {LSRCTL_HOLD, LSRCTL_COUNT, LSRCTL_ARMED} lsrctl_state_t;
endpackage
`default_nettype wire

/* hw/lsrctl_debounce.sv */
// Two-flop synchroniser followed by a stable-time debouncer for one input.
// Assumes the input is asynchronous to clock.
`timescale 1ns/1ns
`default_nettype none
module lsrctl_debounce
    import lsrctl_pkg::*;
#(
    parameter int unsigned SETTLE = lsrctl_pkg::DEBOUNCE_CYC
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic raw,
    output logic clean
);
    import lsrctl_pkg::*;

    logic meta_r, sync_r, clean_r, clean_nxt;
    logic [DB_W-1:0] cnt_r, cnt_nxt;

    // The count restarts whenever the synced level agrees with the output.
    always_comb begin
        clean_nxt = clean_r;
        cnt_nxt = '0;
        if (sync_r != clean_r) begin
            if (cnt_r == DB_W'(SETTLE - 1)) begin
                clean_nxt = sync_r;
            end else begin
                cnt_nxt = cnt_r + 1'b1;
            end
        end
    end

    // The first stage feeds only the second stage, to contain metastability.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            clean_r <= 1'b0;
            cnt_r <= '0;
        end else begin
            meta_r <= raw;
            sync_r <= meta_r;
            clean_r <= clean_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign clean = clean_r;
endmodule // lsrctl_debounce
`default_nettype wire

/* hw/lsrctl_top.sv */
// Laser enable and interlock control: inputs in, RF enable, shutter, lamps out.
// Assumes isolated inputs arrive already level-shifted as active-high logic levels.
// Functional notes
// - Reset/start request holds laser disabled.
// - Request release lights ready, starts five-second countdown.
// - Request asserted removes RF stage power.
// - Interlock absent removes RF stage power.
// - Interlock fault not latched; restart after delay.
// - Interlock absent shows fault lamp red.
// - Interlock open closes shutter, clears ready and shutter lamps.
// - Shutter opens only with request and interlock.
// - Power scales with PWM duty, 50 percent full.
// - Ready output asserted; lasing inhibited first five seconds.
`timescale 1ns/1ns
`default_nettype none
module lsrctl_top
    import lsrctl_pkg::*;
#(
    parameter longint unsigned START_CYC = lsrctl_pkg::START_DELAY_CYC,
    parameter int unsigned SETTLE_CYC = lsrctl_pkg::DEBOUNCE_CYC
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic interlock_in,
    input wire logic shutter_req_in,
    input wire logic restart_req_in,
    input wire logic pwm_in,
    output logic rf_power_en,
    output logic lase_gate,
    output logic shutter_open,
    output logic ready_lamp,
    output logic shutter_lamp,
    output logic interlock_fault_lamp,
    output logic [lsrctl_pkg::PWR_W-1:0] power_level
);
    import lsrctl_pkg::*;

    logic ilk, shreq, rreq, pwm_meta_r, pwm_r, pwm_d_r;
    lsrctl_state_t state_r, state_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic rf_r, rf_nxt, gate_r, gate_nxt, shut_r, shut_nxt;
    logic rdy_r, rdy_nxt, slamp_r, slamp_nxt, fault_r, fault_nxt;
    logic [CNT_W-1:0] per_cnt_r, per_cnt_nxt, hi_cnt_r, hi_cnt_nxt;
    logic [PWR_W-1:0] pwr_r, pwr_nxt;

    // Level inputs are synchronised and debounced before any decision.
    lsrctl_debounce #(.SETTLE(SETTLE_CYC)) u_db_ilk (
        .clock(clock), .rst_b(rst_b), .raw(interlock_in), .clean(ilk));
    lsrctl_debounce #(.SETTLE(SETTLE_CYC)) u_db_sh (
        .clock(clock), .rst_b(rst_b), .raw(shutter_req_in), .clean(shreq));
    lsrctl_debounce #(.SETTLE(SETTLE_CYC)) u_db_rr (
        .clock(clock), .rst_b(rst_b), .raw(restart_req_in), .clean(rreq));

    // Enable sequencing; any loss of permission drops back to hold, so a fault is never latched.
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        if (rreq || !ilk) begin
            state_nxt = LSRCTL_HOLD;
            cnt_nxt = '0;
        end else begin
            unique case (state_r)
                LSRCTL_HOLD: begin
                    state_nxt = LSRCTL_COUNT;
                    cnt_nxt = '0;
                end
                LSRCTL_COUNT: begin
                    if (cnt_r == CNT_W'(START_CYC - 1)) begin
                        state_nxt = LSRCTL_ARMED;
                    end else begin
                        cnt_nxt = cnt_r + 1'b1;
                    end
                end
                LSRCTL_ARMED: begin
                    state_nxt = LSRCTL_ARMED;
                end
            endcase
        end
    end

    // Output decisions registered so every output comes straight from a flip-flop.
    always_comb begin
        rf_nxt = ilk && !rreq;
        rdy_nxt = ilk && !rreq;
        shut_nxt = ilk && shreq;
        slamp_nxt = ilk && shreq && !rreq;
        fault_nxt = !ilk;
        // Lasing needs the delay done and the shutter indication lit.
        gate_nxt = (state_nxt == LSRCTL_ARMED) && shut_nxt && rf_nxt;
    end

    // Duty measurement: high time over period, scaled so 50 percent duty is full code.
    always_comb begin
        // Both counters saturate, so a long pause in the command cannot wrap into a false code.
        per_cnt_nxt = (per_cnt_r == '1) ? per_cnt_r : per_cnt_r + 1'b1;
        hi_cnt_nxt = hi_cnt_r;
        if (pwm_r && (hi_cnt_r != '1)) begin
            hi_cnt_nxt = hi_cnt_r + 1'b1;
        end
        pwr_nxt = pwr_r;
        if (pwm_r && !pwm_d_r) begin
            // Code = 2 * 255 * high / period, saturating at full.
            if ((hi_cnt_r << 1) >= per_cnt_r) begin
                pwr_nxt = PWR_FULL;
            end else begin
                pwr_nxt = PWR_W'(((64'(hi_cnt_r) << 1) * 64'(PWR_FULL)) / 64'(per_cnt_r));
            end
            per_cnt_nxt = CNT_W'(1);
            hi_cnt_nxt = CNT_W'(1);
        end
        if (!gate_r) begin
            pwr_nxt = PWR_RESET;
        end
    end

    // Registers; PWM pin passes two flip-flops first.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= LSRCTL_HOLD;
            cnt_r <= '0;
            rf_r <= 1'b0;
            gate_r <= 1'b0;
            shut_r <= 1'b0;
            rdy_r <= 1'b0;
            slamp_r <= 1'b0;
            fault_r <= 1'b1;
            pwm_meta_r <= 1'b0;
            pwm_r <= 1'b0;
            pwm_d_r <= 1'b0;
            per_cnt_r <= '0;
            hi_cnt_r <= '0;
            pwr_r <= PWR_RESET;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            rf_r <= rf_nxt;
            gate_r <= gate_nxt;
            shut_r <= shut_nxt;
            rdy_r <= rdy_nxt;
            slamp_r <= slamp_nxt;
            fault_r <= fault_nxt;
            pwm_meta_r <= pwm_in;
            pwm_r <= pwm_meta_r;
            pwm_d_r <= pwm_r;
            per_cnt_r <= per_cnt_nxt;
            hi_cnt_r <= hi_cnt_nxt;
            pwr_r <= pwr_nxt;
        end
    end

    assign rf_power_en = rf_r;
    assign lase_gate = gate_r;
    assign shutter_open = shut_r;
    assign ready_lamp = rdy_r;
    assign shutter_lamp = slamp_r;
    assign interlock_fault_lamp = fault_r;
    assign power_level = pwr_r;

    // Request held: RF power stays off.
    property p_req_holds_off;
        @(posedge clock) disable iff (!rst_b) rreq |=> !rf_power_en && !lase_gate;
    endproperty
    a_req_holds_off: assert property (p_req_holds_off) else $error("RF on during request");

    property p_req_rf;
        @(posedge clock) disable iff (!rst_b) $rose(rreq) |=> !rf_power_en;
    endproperty
    a_req_rf: assert property (p_req_rf) else $error("RF not dropped on request");

    property p_ilk_rf;
        @(posedge clock) disable iff (!rst_b) !ilk |=> !rf_power_en;
    endproperty
    a_ilk_rf: assert property (p_ilk_rf) else $error("RF on without interlock");

    property p_fault_lamp;
        @(posedge clock) disable iff (!rst_b) !ilk |=> interlock_fault_lamp;
    endproperty
    a_fault_lamp: assert property (p_fault_lamp) else $error("Fault lamp not lit");

    sequence s_ilk_open;
        $fell(ilk);
    endsequence
    property p_ilk_open_all;
        @(posedge clock) disable iff (!rst_b)
            s_ilk_open |=> !shutter_open && !ready_lamp && !shutter_lamp && !rf_power_en;
    endproperty
    a_ilk_open_all: assert property (p_ilk_open_all) else $error("Interlock open not obeyed");

    property p_shutter_needs_ilk;
        @(posedge clock) disable iff (!rst_b) shutter_open |-> $past(ilk) && $past(shreq);
    endproperty
    a_shutter_needs_ilk: assert property (p_shutter_needs_ilk) else $error("Shutter without ilk");

    property p_release_ready;
        @(posedge clock) disable iff (!rst_b) $fell(rreq) && ilk |=> ready_lamp && !lase_gate;
    endproperty
    a_release_ready: assert property (p_release_ready) else $error("Ready not lit on release");

    property p_inhibit;
        @(posedge clock) disable iff (!rst_b) $rose(ready_lamp) |-> !lase_gate [*8];
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("Lasing inside start delay");

    // Cycles since the ready lamp lit, saturating, so the whole start delay can be checked.
    logic [CNT_W-1:0] rdy_age_r, rdy_age_nxt;
    always_comb begin
        rdy_age_nxt = '0;
        if (ready_lamp) begin
            rdy_age_nxt = (rdy_age_r == '1) ? rdy_age_r : rdy_age_r + 1'b1;
        end
    end

    // Checker-only age register; it never feeds the outputs.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rdy_age_r <= '0;
        end else begin
            rdy_age_r <= rdy_age_nxt;
        end
    end

    property p_delay_full;
        @(posedge clock) disable iff (!rst_b) lase_gate |-> rdy_age_r >= CNT_W'(START_CYC);
    endproperty
    a_delay_full: assert property (p_delay_full) else $error("Lasing before delay");

    property p_abort;
        @(posedge clock) disable iff (!rst_b)
            (state_r == LSRCTL_COUNT) && (rreq || !ilk) |=> state_r == LSRCTL_HOLD && cnt_r == '0;
    endproperty
    a_abort: assert property (p_abort) else $error("Countdown not aborted");

    property p_gate_shutter;
        @(posedge clock) disable iff (!rst_b) lase_gate |-> shutter_lamp && state_r == LSRCTL_ARMED;
    endproperty
    a_gate_shutter: assert property (p_gate_shutter) else $error("Gate without shutter");

    property p_pwr_off;
        @(posedge clock) disable iff (!rst_b) !lase_gate |=> power_level == PWR_RESET;
    endproperty
    a_pwr_off: assert property (p_pwr_off) else $error("Power while not gated");
endmodule // lsrctl_top
`default_nettype wire

/* verif/lsrctl_plc_model.sv */
// Machine controller model driving the four isolated control inputs.
// Assumes the bench sets wanted levels and the PWM high time.
`timescale 1ns/1ns
`default_nettype none
module lsrctl_plc_model #(
    parameter int PERIOD = 2500
) (
    input wire logic clock,
    input wire logic ilk_set,
    input wire logic shreq_set,
    input wire logic rreq_set,
    input wire logic [11:0] high_set,
    output var logic interlock_in,
    output var logic shutter_req_in,
    output var logic restart_req_in,
    output var logic pwm_in
);
    int phase = 0;
    // Levels move on the falling edge, clear of the sampling edge.
    initial begin
        interlock_in = 1'b0;
        shutter_req_in = 1'b0;
        restart_req_in = 1'b1;
        pwm_in = 1'b0;
    end
    // Period of 2500 cycles is 100 kHz; a high time above 45 percent drives no pulse at all.
    always @(negedge clock) begin
        interlock_in <= ilk_set;
        shutter_req_in <= shreq_set;
        restart_req_in <= rreq_set;
        phase <= (phase == PERIOD - 1) ? 0 : phase + 1;
        pwm_in <= (phase < int'(high_set)) && (int'(high_set) <= PERIOD * 45 / 100);
    end
endmodule // lsrctl_plc_model
`default_nettype wire

/* verif/testbench.sv */
// Self-checking bench for the laser enable and interlock control.
// Assumes short start delay and debounce parameters for simulation.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import lsrctl_pkg::*;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic i = 1'b0;
    logic s = 1'b0;
    logic r = 1'b1;
    logic [11:0] high = 12'h465;
    wire logic ilk_w, shr_w, rr_w, pwm_w;
    logic rf, lase, sh_open, rdy, sh_lamp, fault;
    logic [PWR_W-1:0] pwr;
    int n_fail = 0;
    int samples_checked = 0;
    int seed = 32'h8068;
    int en_a = 0;
    int en_b = 0;
    int step;
    lsrctl_plc_model #(.PERIOD(2500)) i_plc (.clock(clock), .ilk_set(i), .shreq_set(s),
        .rreq_set(r), .high_set(high), .interlock_in(ilk_w), .shutter_req_in(shr_w),
        .restart_req_in(rr_w), .pwm_in(pwm_w));
    lsrctl_top #(.START_CYC(64'd60), .SETTLE_CYC(4)) i_dut (.clock(clock), .rst_b(rst_b),
        .interlock_in(ilk_w), .shutter_req_in(shr_w), .restart_req_in(rr_w),
        .pwm_in(pwm_w), .rf_power_en(rf), .lase_gate(lase), .shutter_open(sh_open),
        .ready_lamp(rdy), .shutter_lamp(sh_lamp), .interlock_fault_lamp(fault),
        .power_level(pwr));
    // Free-running 250 MHz clock.
    initial forever #2 clock = ~clock;
    task automatic end_of_test();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Power is only approximate, so a small tolerance is allowed.
    task automatic cmp_pwr(input logic [PWR_W-1:0] got, input int exp);
        samples_checked++;
        if ($isunknown(got) || int'(got) > exp + 4 || int'(got) < exp - 4) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Linear scale where half of a 2500-cycle period is full power.
    function automatic int exp_pwr(input int hi);
        int v;
        v = hi * 510 / 2500;
        return (v > 255) ? 255 : v;
    endfunction
    task automatic hold(input logic a, input logic b, input logic c, input int n);
        @(negedge clock);
        i = a;
        s = b;
        r = c;
        repeat (n - 1) @(negedge clock);
    endtask
    // Random input mixes, thirty cycles each, then the corner cases.
    initial begin
        repeat (5) @(posedge clock);
        cmp_bit(rf, 1'b0);
        cmp_bit(fault, 1'b1);
        @(negedge clock);
        rst_b = 1'b1;
        for (int k = 0; k < 60; k++) begin
            step = $random(seed);
            hold(step[0] | step[1], step[2] | step[3], step[4] & step[5], 30);
            en_a = (i && !r) ? en_a + 30 : 0;
            en_b = (i && !r && s) ? en_b + 30 : 0;
            cmp_bit(rf, i && !r);
            cmp_bit(rdy, i && !r);
            cmp_bit(fault, !i);
            cmp_bit(sh_open, i && s);
            if (!r) cmp_bit(sh_lamp, i && s);
            if (r) cmp_bit(lase, 1'b0);
            if (s && en_b >= 90) cmp_bit(lase, 1'b1);
            else if (!s || en_a <= 60) cmp_bit(lase, 1'b0);
            if (!s || en_a <= 60) cmp_pwr(pwr, 0);
        end
        hold(1'b1, 1'b1, 1'b0, 100);
        cmp_bit(lase, 1'b1);
        // A two-cycle interlock dropout must be filtered out.
        hold(1'b0, 1'b1, 1'b0, 2);
        hold(1'b1, 1'b1, 1'b0, 20);
        cmp_bit(lase, 1'b1);
        for (int j = 0; j < 3; j++) begin
            high = (j == 0) ? 12'h233 : (j == 1) ? 12'h2EE : 12'h465;
            repeat (7500) @(negedge clock);
            cmp_pwr(pwr, exp_pwr(int'(high)));
        end
        end_of_test();
    end
    // Watchdog cuts a hang short well past the expected run length.
    initial begin
        #200000;
        n_fail++;
        end_of_test();
    end
endmodule // testbench
`default_nettype wire
